// File: rtl/ext_irq_defines.vh
// External interrupt and vector placement block: constants.
// Assumes an APB slave with 32-bit data, one register per aligned word.
// Operation
// - Select bit picks flash start or boot
// - Block servicing from unlock until after next
// - Unwritten unlock releases block after four cycles
// - Blocking leaves global enable flag untouched
// - Boot vectors plus app lock: no app irqs
// - App vectors plus boot lock: no boot irqs
// - Unlock self-clears after four cycles or write
// - Boot start address from boot size fuses
// - Pins driven as outputs still trigger
// - Three pin-change groups of eight pins
// - Mask bit gates each pin-change input
// - Pin-change detection needs no I/O clock
// - Level sense requests while pin low
// - Pins 3..0 detected without I/O clock
// - Vanished wake level gives no interrupt
// - Sense codes: low, any, falling, rising
// - Taken only with global and mask set
// - Flag set on edge, cleared, zero in level
// - Pins 7..4 sampled; long pulses caught
`ifndef EXT_IRQ_DEFINES_VH
`define EXT_IRQ_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_MCU_CONTROL 12'h000
`define ADDR_SENSE_LOW 12'h004
`define ADDR_SENSE_HIGH 12'h008
`define ADDR_IRQ_MASK 12'h00c
`define ADDR_IRQ_FLAGS 12'h010
`define ADDR_PC_CONTROL 12'h014
`define ADDR_PC_FLAGS 12'h018
`define ADDR_PC_MASK_LOW 12'h01c
`define ADDR_PC_MASK_MID 12'h020
`define ADDR_PC_MASK_HIGH 12'h024
`define ADDR_BOOT_BASE 12'h028

// ----------------------------------------------------------------
// Fields and codes
// ----------------------------------------------------------------
`define BIT_UNLOCK 0
`define BIT_SELECT 1
`define SENSE_LOW_LEVEL 2'h0
`define SENSE_ANY_EDGE 2'h1
`define SENSE_FALLING 2'h2
`define SENSE_RISING 2'h3
`define UNLOCK_CYCLES 3'h4
`define RESET_BYTE 8'h00

`endif

// File: rtl/edge_capture.v
// Captures one pin's events and brings them into the clock domain.
// Assumes pin is asynchronous; level and prev are the synchronised samples.
`timescale 1ns/100ps
`default_nettype none
module edge_capture (
  input wire clk,
  input wire rst_n,
  input wire pin,
  output reg level,
  output reg prev
);
  reg stage1;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  // sync into clock
  always @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= 1'b1;
      level <= 1'b1;
      prev <= 1'b1;
    end else begin
      stage1 <= pin;
      level <= stage1;
      prev <= level;
    end
  end
endmodule
`default_nettype wire

// File: rtl/boot_base_lookup.v
// Boot section start word address from the boot size fuses.
// Assumes the fuse code is static; output registered.
`timescale 1ns/100ps
`default_nettype none
module boot_base_lookup #(
  parameter [16:0] BASE_0 = 17'h1e000,
  parameter [16:0] BASE_1 = 17'h1f000,
  parameter [16:0] BASE_2 = 17'h1f800,
  parameter [16:0] BASE_3 = 17'h1fc00
) (
  input wire clk,
  input wire [1:0] bootSizeFuses,
  output reg [16:0] bootBase
);
  // ----------------------------------------------------------------
  // Table
  // ----------------------------------------------------------------
  // fuse to base
  always @(posedge clk) begin
    case (bootSizeFuses)
      2'h0: bootBase <= BASE_0;
      2'h1: bootBase <= BASE_1;
      2'h2: bootBase <= BASE_2;
      default: bootBase <= BASE_3;
    endcase
  end
endmodule
`default_nettype wire

// File: rtl/ext_irq_and_vector_select.v
// External interrupts, pin-change groups and vector placement control.
// Assumes APB master on clk; pins asynchronous; core reports cycles.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_defines.vh"
module ext_irq_and_vector_select (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] extIrqPins,
  input wire [23:0] pinChangeInputs,
  input wire globalIrqEnable,
  input wire instrDone,
  input wire execInBoot,
  input wire appSideBootLock,
  input wire bootSideBootLock,
  input wire [1:0] bootSizeFuses,
  input wire wakeComplete,
  input wire [7:0] extIrqAck,
  input wire [2:0] pinChangeAck,
  output reg [7:0] extIrqReq,
  output reg [2:0] pinChangeReq,
  output reg irqBlocked,
  output reg [16:0] vectorBase
);
  reg vectorBaseSelect;
  reg vectorChangeUnlock;
  reg [2:0] unlockCount;
  reg holdState;
  reg [7:0] senseLow;
  reg [7:0] senseHigh;
  reg [7:0] extIrqMask;
  reg [7:0] extIrqFlags;
  reg [2:0] pcEnable;
  reg [2:0] pcFlags;
  reg [7:0] pcMaskLow;
  reg [7:0] pcMaskMid;
  reg [7:0] pcMaskHigh;
  wire [7:0] lvl;
  wire [7:0] prv;
  wire [23:0] pcLvl;
  wire [23:0] pcPrv;
  wire [16:0] bootBase;
  reg [7:0] trig;
  reg [7:0] isLevel;
  reg [2:0] pcTrig;
  reg [31:0] next_prdata;
  reg mapped;
  integer i;
  integer j;
  integer r;

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT_INSTR = 1'b1;

  function [1:0] senseOf;
    input [7:0] lowReg;
    input [7:0] highReg;
    input [2:0] n;
    reg [15:0] all;
    begin
      all = {highReg, lowReg};
      senseOf = all[{n, 1'b0} +: 2];
    end
  endfunction

  wire access = psel & penable;
  wire wrEn = access & pwrite;
  wire wrMcu = wrEn & (paddr == `ADDR_MCU_CONTROL);
  wire selWrite = wrMcu & vectorChangeUnlock & ~pwdata[`BIT_UNLOCK];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // sampled pins
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : extSync
      edge_capture uExt (
        .clk(clk),
        .rst_n(rst_n),
        .pin(extIrqPins[g]),
        .level(lvl[g]),
        .prev(prv[g])
      );
    end
    for (g = 0; g < 24; g = g + 1) begin : pcSync
      edge_capture uPc (
        .clk(clk),
        .rst_n(rst_n),
        .pin(pinChangeInputs[g]),
        .level(pcLvl[g]),
        .prev(pcPrv[g])
      );
    end
  endgenerate

  boot_base_lookup uBoot (
    .clk(clk),
    .bootSizeFuses(bootSizeFuses),
    .bootBase(bootBase)
  );

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      case (senseOf(senseLow, senseHigh, i[2:0]))
        `SENSE_LOW_LEVEL: trig[i] = 1'b0;
        `SENSE_ANY_EDGE: trig[i] = lvl[i] ^ prv[i];
        `SENSE_FALLING: trig[i] = ~lvl[i] & prv[i];
        default: trig[i] = lvl[i] & ~prv[i];
      endcase
      isLevel[i] = senseOf(senseLow, senseHigh, i[2:0]) ==
        `SENSE_LOW_LEVEL;
    end
    pcTrig[0] = |((pcLvl[7:0] ^ pcPrv[7:0]) & pcMaskLow);
    pcTrig[1] = |((pcLvl[15:8] ^ pcPrv[15:8]) & pcMaskMid);
    pcTrig[2] = |((pcLvl[23:16] ^ pcPrv[23:16]) & pcMaskHigh);
  end

  // ----------------------------------------------------------------
  // Vector placement and unlock
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      vectorBaseSelect <= 1'b0;
      vectorChangeUnlock <= 1'b0;
      unlockCount <= 3'h0;
      holdState <= ST_IDLE;
    end else begin
      case (holdState)
        ST_IDLE: begin
          if (selWrite) begin
            vectorBaseSelect <= pwdata[`BIT_SELECT];
            vectorChangeUnlock <= 1'b0;
            holdState <= ST_WAIT_INSTR;
          end else if (wrMcu & pwdata[`BIT_UNLOCK]) begin
            vectorChangeUnlock <= 1'b1;
            unlockCount <= `UNLOCK_CYCLES;
          end else if (vectorChangeUnlock) begin
            if (unlockCount == 3'h1)
              vectorChangeUnlock <= 1'b0;
            unlockCount <= unlockCount - 3'h1;
          end
        end
        ST_WAIT_INSTR: begin
          if (instrDone)
            holdState <= ST_IDLE;
        end
        default: holdState <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers and flags
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      senseLow <= `RESET_BYTE;
      senseHigh <= `RESET_BYTE;
      extIrqMask <= `RESET_BYTE;
      extIrqFlags <= `RESET_BYTE;
      pcEnable <= 3'h0;
      pcFlags <= 3'h0;
      pcMaskLow <= `RESET_BYTE;
      pcMaskMid <= `RESET_BYTE;
      pcMaskHigh <= `RESET_BYTE;
    end else begin
      if (wrEn) begin
        case (paddr)
          `ADDR_SENSE_LOW: senseLow <= pwdata[7:0];
          `ADDR_SENSE_HIGH: senseHigh <= pwdata[7:0];
          `ADDR_IRQ_MASK: extIrqMask <= pwdata[7:0];
          `ADDR_PC_CONTROL: pcEnable <= pwdata[2:0];
          `ADDR_PC_MASK_LOW: pcMaskLow <= pwdata[7:0];
          `ADDR_PC_MASK_MID: pcMaskMid <= pwdata[7:0];
          `ADDR_PC_MASK_HIGH: pcMaskHigh <= pwdata[7:0];
          default: ;
        endcase
      end
      // set beats clear; level mode keeps zero
      for (j = 0; j < 8; j = j + 1) begin
        if (isLevel[j])
          extIrqFlags[j] <= 1'b0;
        else if (trig[j])
          extIrqFlags[j] <= 1'b1;
        else if (extIrqAck[j] |
                 (wrEn & (paddr == `ADDR_IRQ_FLAGS) & pwdata[j]))
          extIrqFlags[j] <= 1'b0;
      end
      for (j = 0; j < 3; j = j + 1) begin
        if (pcTrig[j])
          pcFlags[j] <= 1'b1;
        else if (pinChangeAck[j] |
                 (wrEn & (paddr == `ADDR_PC_FLAGS) & pwdata[j]))
          pcFlags[j] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Requests to the core
  // ----------------------------------------------------------------
  wire lockSuppress = (vectorBaseSelect & appSideBootLock & ~execInBoot) |
    (~vectorBaseSelect & bootSideBootLock & execInBoot);
  wire autoBlock = vectorChangeUnlock | (wrMcu & pwdata[`BIT_UNLOCK]) |
    holdState == ST_WAIT_INSTR;
  wire gate = globalIrqEnable & ~autoBlock & ~lockSuppress;

  always @(posedge clk) begin
    if (!rst_n) begin
      extIrqReq <= 8'h00;
      pinChangeReq <= 3'h0;
      irqBlocked <= 1'b0;
      vectorBase <= 17'h00000;
    end else begin
      for (r = 0; r < 8; r = r + 1) begin
        // live low level; gone level gives none
        extIrqReq[r] <= gate & extIrqMask[r] &
          (isLevel[r] ? (~lvl[r] & wakeComplete) : extIrqFlags[r]);
      end
      pinChangeReq <= {3{gate}} & pcEnable & pcFlags;
      irqBlocked <= autoBlock | lockSuppress;
      vectorBase <= vectorBaseSelect ? bootBase : 17'h00000;
    end
  end

  // ----------------------------------------------------------------
  // APB read and answer
  // ----------------------------------------------------------------
  always @* begin
    next_prdata = 32'h00000000;
    mapped = 1'b1;
    case (paddr)
      `ADDR_MCU_CONTROL:
        next_prdata[1:0] = {vectorBaseSelect, vectorChangeUnlock};
      `ADDR_SENSE_LOW: next_prdata[7:0] = senseLow;
      `ADDR_SENSE_HIGH: next_prdata[7:0] = senseHigh;
      `ADDR_IRQ_MASK: next_prdata[7:0] = extIrqMask;
      `ADDR_IRQ_FLAGS: next_prdata[7:0] = extIrqFlags;
      `ADDR_PC_CONTROL: next_prdata[2:0] = pcEnable;
      `ADDR_PC_FLAGS: next_prdata[2:0] = pcFlags;
      `ADDR_PC_MASK_LOW: next_prdata[7:0] = pcMaskLow;
      `ADDR_PC_MASK_MID: next_prdata[7:0] = pcMaskMid;
      `ADDR_PC_MASK_HIGH: next_prdata[7:0] = pcMaskHigh;
      `ADDR_BOOT_BASE: next_prdata[16:0] = bootBase;
      default: mapped = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
        prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire

// File: testbench/ext_irq_props.sv
// Port checker for the interrupt and vector placement block.
// Assumes it is bound to ext_irq_and_vector_select, one clock.
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_defines.vh"
module ext_irq_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic globalIrqEnable,
  input wire logic instrDone,
  input wire logic appSideBootLock,
  input wire logic bootSideBootLock,
  input wire logic [7:0] extIrqReq,
  input wire logic irqBlocked,
  input wire logic [16:0] vectorBase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire mcuWr = psel && penable && pready && pwrite &&
    paddr == `ADDR_MCU_CONTROL;
  wire noLock = !appSideBootLock && !bootSideBootLock;
  sequence unlockWr;
    mcuWr && pwdata[`BIT_UNLOCK] && noLock;
  endsequence
  sequence selectWr;
    mcuWr && !pwdata[`BIT_UNLOCK] && irqBlocked && noLock;
  endsequence
  a_unlock_blocks: assert property (
    unlockWr |-> ##[1:2] irqBlocked) else $error("no block after unlock");
  a_unlock_expires: assert property (
    unlockWr ##1 (!mcuWr && noLock) [*6] |-> !irqBlocked)
    else $error("block outlived unlock");
  a_select_holds: assert property (
    selectWr ##1 (!instrDone && noLock) [*2] |-> irqBlocked)
    else $error("block dropped before instruction end");
  a_vector_moves: assert property (
    $changed(vectorBase) |-> $past(mcuWr) || $past(mcuWr, 2))
    else $error("vector base moved without write");
  a_enable_gates: assert property (
    (!globalIrqEnable) [*2] |-> extIrqReq == 8'h00)
    else $error("request with global enable low");
  a_ready_answers: assert property (
    psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("ready longer than one cycle");
  a_error_decode: assert property (
    pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > `ADDR_BOOT_BASE))
    else $error("error response wrong for address");
  a_error_timing: assert property (
    pslverr |-> pready && psel && penable) else $error("stray error");
endmodule
bind ext_irq_and_vector_select ext_irq_props chk (.clk(clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .globalIrqEnable(globalIrqEnable), .instrDone(instrDone),
  .appSideBootLock(appSideBootLock), .bootSideBootLock(bootSideBootLock),
  .extIrqReq(extIrqReq), .irqBlocked(irqBlocked),
  .vectorBase(vectorBase));
`default_nettype wire

// File: testbench/pin_core_model.sv
// Pin sources and processor core facing the interrupt block.
// Assumes the bench moves pins and sets ackOn.
`timescale 1ns/100ps
`default_nettype none
module pin_core_model (
  input wire logic clk,
  input wire logic [7:0] extIrqReq,
  input wire logic [2:0] pinChangeReq,
  output logic [7:0] extIrqPins,
  output logic [23:0] pinChangeInputs,
  output logic instrDone,
  output logic [7:0] extIrqAck,
  output logic [2:0] pinChangeAck
);
  logic ackOn = 1'b0;
  logic [1:0] step = 2'h0;
  initial begin
    extIrqPins = 8'hff;
    pinChangeInputs = 24'hffffff;
    instrDone = 1'b0;
    extIrqAck = 8'h00;
    pinChangeAck = 3'h0;
  end
  always @(posedge clk) begin
    step <= step + 2'h1;
    instrDone <= step == 2'h3;
    extIrqAck <= ackOn ? extIrqReq & ~extIrqAck : 8'h00;
    pinChangeAck <= ackOn ? pinChangeReq & ~pinChangeAck : 3'h0;
  end
endmodule
`default_nettype wire

// File: testbench/test_ext_irq_and_vector_select.sv
// Self-checking bench for the interrupt and vector placement block.
// Assumes default boot bases in the design; pins idle high.
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_defines.vh"
module test_ext_irq_and_vector_select;
  localparam logic [16:0] BOOT_BASE = 17'h1f000;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic gie, lockApp, lockBoot, inBoot, instrDone, irqBlocked, wake;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] extIrqPins, extIrqReq, extIrqAck, m;
  logic [23:0] pinChangeInputs;
  logic [2:0] pinChangeReq, pinChangeAck, seen;
  logic [16:0] vectorBase;
  int mismatches = 0, comparisons = 0, seed = 38733, k, n;
  ext_irq_and_vector_select dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extIrqPins(extIrqPins), .pinChangeInputs(pinChangeInputs),
    .globalIrqEnable(gie), .instrDone(instrDone), .execInBoot(inBoot),
    .appSideBootLock(lockApp), .bootSideBootLock(lockBoot),
    .bootSizeFuses(2'b01), .wakeComplete(wake), .extIrqAck(extIrqAck),
    .pinChangeAck(pinChangeAck), .extIrqReq(extIrqReq),
    .pinChangeReq(pinChangeReq), .irqBlocked(irqBlocked),
    .vectorBase(vectorBase));
  pin_core_model model (.clk(clk), .extIrqReq(extIrqReq),
    .pinChangeReq(pinChangeReq), .extIrqPins(extIrqPins),
    .pinChangeInputs(pinChangeInputs), .instrDone(instrDone),
    .extIrqAck(extIrqAck), .pinChangeAck(pinChangeAck));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic expectReq(input logic [1:0] code, input int ph);
    case (ph)
      0: return code != `SENSE_RISING;
      1: return code == `SENSE_LOW_LEVEL;
      default: return code[0];
    endcase
  endfunction
  function automatic logic [2:0] pcExpect(input int idx, input logic [7:0] mk);
    return mk[idx % 8] ? 3'(1 << (idx / 8)) : 3'h0;
  endfunction
  task check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1000000;
    mismatches++;
    complete_run;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, lockApp, lockBoot, inBoot} = 7'h0;
    gie = 1'b1;
    wake = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 7; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0);
      check("reset value", rd, {24'h0, `RESET_BYTE});
    end
    $display("test reset values done");
    apb(1'b1, `ADDR_MCU_CONTROL, 32'h1);
    apb(1'b1, `ADDR_MCU_CONTROL, 32'h2);
    repeat (3) @(posedge clk);
    check("vector base", vectorBase, BOOT_BASE);
    apb(1'b0, `ADDR_MCU_CONTROL, 32'h0);
    check("mcu control", rd, 32'h2);
    apb(1'b0, `ADDR_BOOT_BASE, 32'h0);
    check("boot base", rd, BOOT_BASE);
    lockApp <= 1'b1;
    repeat (4) @(posedge clk);
    check("app lock block", irqBlocked, 1'b1);
    inBoot <= 1'b1;
    repeat (4) @(posedge clk);
    check("boot exec free", irqBlocked, 1'b0);
    lockApp <= 1'b0;
    apb(1'b1, `ADDR_MCU_CONTROL, 32'h0);
    repeat (3) @(posedge clk);
    check("locked select", vectorBase, BOOT_BASE);
    apb(1'b1, `ADDR_MCU_CONTROL, 32'h3);
    repeat (2) @(posedge clk);
    check("unlock block", irqBlocked, 1'b1);
    repeat (8) @(posedge clk);
    check("block released", irqBlocked, 1'b0);
    apb(1'b0, `ADDR_MCU_CONTROL, 32'h0);
    check("unlock cleared", rd, 32'h2);
    apb(1'b1, `ADDR_MCU_CONTROL, 32'h1);
    apb(1'b1, `ADDR_MCU_CONTROL, 32'h0);
    lockBoot <= 1'b1;
    repeat (4) @(posedge clk);
    check("vector base", vectorBase, 32'h0);
    check("boot lock block", irqBlocked, 1'b1);
    {lockBoot, inBoot} <= 2'b00;
    $display("test vector placement done");
    for (k = 0; k < 4; k++) begin
      apb(1'b1, `ADDR_IRQ_MASK, 32'h0);
      apb(1'b1, `ADDR_SENSE_LOW, k);
      apb(1'b1, `ADDR_IRQ_FLAGS, 32'hff);
      apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
      model.extIrqPins[0] <= 1'b0;
      repeat (6) @(posedge clk);
      check("request on fall", extIrqReq[0], expectReq(k, 0));
      apb(1'b1, `ADDR_IRQ_FLAGS, 32'h1);
      repeat (2) @(posedge clk);
      check("request kept", extIrqReq[0], expectReq(k, 1));
      model.extIrqPins[0] <= 1'b1;
      repeat (6) @(posedge clk);
      check("request on rise", extIrqReq[0], expectReq(k, 2));
    end
    apb(1'b1, `ADDR_SENSE_LOW, 32'h0);
    model.extIrqPins[0] <= 1'b0;
    gie <= 1'b0;
    repeat (5) @(posedge clk);
    check("enable off", extIrqReq[0], 1'b0);
    gie <= 1'b1;
    repeat (3) @(posedge clk);
    check("enable on", extIrqReq[0], 1'b1);
    wake <= 1'b0;
    repeat (3) @(posedge clk);
    check("level before wake", extIrqReq[0], 1'b0);
    model.extIrqPins[0] <= 1'b1;
    repeat (3) @(posedge clk);
    wake <= 1'b1;
    repeat (3) @(posedge clk);
    check("vanished level", extIrqReq[0], 1'b0);
    $display("test sense modes done");
    apb(1'b1, `ADDR_PC_CONTROL, 32'h7);
    model.ackOn <= 1'b1;
    for (k = 0; k < 12; k++) begin
      m = $random(seed);
      n = {$random(seed)} % 24;
      apb(1'b1, 12'(`ADDR_PC_MASK_LOW + 4 * (n / 8)), {24'h0, m});
      seen = 3'h0;
      model.pinChangeInputs[n] <= ~model.pinChangeInputs[n];
      repeat (8) begin
        @(posedge clk);
        seen = seen | pinChangeReq;
      end
      check("group request", seen, pcExpect(n, m));
    end
    $display("test pin change done");
    apb(1'b0, 12'h030, 32'h0);
    check("unmapped data", rd, 32'h0);
    check("unmapped error", err, 1'b1);
    $display("test unmapped done");
    complete_run;
  end
endmodule
`default_nettype wire
